/* File: hdl/dio_query_map.vh */
// Purpose: Offsets, field codes, characters and counts of the status query responder
// Assumes: Included by the design files by bare name
// Notes: Register offsets are byte addresses of aligned 32-bit words
`ifndef DIO_QUERY_MAP_VH
`define DIO_QUERY_MAP_VH

// Register offsets
`define OFS_CMD 8'h00
`define OFS_REPLY 8'h04
`define OFS_STATUS 8'h08
`define OFS_DIR 8'h0c
`define OFS_SENSE 8'h10
`define OFS_LEVEL 8'h14
`define OFS_PULSE 8'h18
`define OFS_IRQ 8'h1c
`define OFS_STRB_CLR 8'h20

// Writable field masks and reset values
`define MASK_BYTES 6'h3f
`define MASK_IRQ 8'hdd
`define RST_SOFT_TS 6'h3f
`define RST_DIR 6'h00
`define RST_SENSE 6'h00
`define RST_LEVEL 6'h00
`define RST_PULSE 6'h00
`define RST_IRQ 8'h00

// Field positions
`define PULSE_DRD_EDGE 0
`define PULSE_RFD_EDGE 1
`define STRB_CLR_DRD 0
`define STRB_CLR_RFD 1
`define STAT_BUSY 0
`define STAT_ERR 1
`define STAT_DRD 2
`define STAT_RFD 3
`define STAT_FAIL 4

// Read modes
`define RM_READY 4'h0
`define RM_TEXT 4'h1
`define RM_NUM 4'h2
`define RM_DRD 4'h3
`define RM_RFD 4'h4
`define RM_IRQ 4'h5
`define RM_LEVEL 4'h6
`define RM_DIR 4'h7
`define RM_PULSE 4'h8
`define RM_SENSE 4'h9
`define RM_TS 4'ha

// Error codes
`define ERR_NONE 7'd0
`define ERR_SELFTEST 7'd1
`define ERR_SYNTAX 7'd2
`define ERR_TRISTATE 7'd7
`define ERR_OUT_ON_IN 7'd10
`define ERR_SEQ_LEN 7'd15

// Characters
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_SEMI 8'h3b
`define CH_SPACE 8'h20
`define CH_STAR 8'h2a
`define CH_ZERO 8'h30
`define CH_FIVE 8'h35

// Self test counts
`define ST_LAST_BYTE 3'h5
`define ST_LAST_PAT 8'hff

`endif

/* File: hdl/hex_char.v */
// Purpose: Converts one nibble to its upper-case ASCII hex character
// Assumes: Purely combinational
// Notes: Used for both characters of a two-character hex reply
`timescale 1ns/1ps
module hex_char (
   input wire [3:0] nib_i,
   output reg [7:0] ch_o
);
   // Digits 0-9 then A-F
   always @* begin
      if (nib_i < 4'ha) begin
         ch_o = 8'h30 + {4'h0, nib_i};
      end else begin
         ch_o = 8'h37 + {4'h0, nib_i};
      end
   end
endmodule

/* File: hdl/reply_text.v */
// Purpose: Character source for the error text reply
// Assumes: idx_i below len_o selects a body character; caller adds CR LF
// Notes: Templates carry '#' where a field is substituted
`timescale 1ns/1ps
`include "dio_query_map.vh"
module reply_text (
   input wire [6:0] code_i,
   input wire [7:0] arg_a_i,
   input wire [7:0] arg_b_i,
   input wire [5:0] idx_i,
   output reg [7:0] ch_o,
   output reg [5:0] len_o
);
   localparam [8*37-1:0] T_NONE = "NO ERRORS";
   localparam [8*37-1:0] T_ST = "SELF TEST FAILURE BYTE # COUNT ###";
   localparam [8*37-1:0] T_SYN = "SYNTAX ERROR";
   localparam [8*37-1:0] T_TS = "INVALID TRI-STATE COMMAND '#'";
   localparam [8*37-1:0] T_OUT = "OUTPUT SPECIFIED ON AN INPUT BYTE - #";
   localparam [8*37-1:0] T_SEQ = "MAXIMUM SEQUENCE LENGTH EXCEEDED - ##";
   localparam [8*37-1:0] T_UNK = "UNKNOWN ERROR";

   // Character i of an n-character right-aligned template
   function [7:0] pick;
      input [8*37-1:0] s;
      input [5:0] n;
      input [5:0] i;
      begin
         if (i < n) begin
            pick = s[8*(n-1-i) +: 8];
         end else begin
            pick = 8'h20;
         end
      end
   endfunction

   // Decimal digit of a value below ten
   function [7:0] dig;
      input [7:0] v;
      begin
         dig = 8'h30 + v;
      end
   endfunction

   // Template choice then field substitution
   always @* begin
      case (code_i)
         `ERR_NONE: begin
            len_o = 6'd9;
            ch_o = pick(T_NONE, 6'd9, idx_i);
         end
         `ERR_SELFTEST: begin
            len_o = 6'd34;
            ch_o = pick(T_ST, 6'd34, idx_i);
            if (idx_i == 6'd23) ch_o = dig({5'h0, arg_a_i[2:0]});
            if (idx_i == 6'd31) ch_o = dig(arg_b_i / 8'd100);
            if (idx_i == 6'd32) ch_o = dig((arg_b_i / 8'd10) % 8'd10);
            if (idx_i == 6'd33) ch_o = dig(arg_b_i % 8'd10);
         end
         `ERR_SYNTAX: begin
            len_o = 6'd12;
            ch_o = pick(T_SYN, 6'd12, idx_i);
         end
         `ERR_TRISTATE: begin
            len_o = 6'd29;
            ch_o = pick(T_TS, 6'd29, idx_i);
            if (idx_i == 6'd27) ch_o = arg_a_i; // Offending character
         end
         `ERR_OUT_ON_IN: begin
            len_o = 6'd37;
            ch_o = pick(T_OUT, 6'd37, idx_i);
            if (idx_i == 6'd36) ch_o = dig({5'h0, arg_a_i[2:0]});
         end
         `ERR_SEQ_LEN: begin
            len_o = 6'd37;
            ch_o = pick(T_SEQ, 6'd37, idx_i);
            if (idx_i == 6'd35) ch_o = dig(arg_a_i / 8'd10);
            if (idx_i == 6'd36) ch_o = dig(arg_a_i % 8'd10);
         end
         default: begin
            len_o = 6'd13;
            ch_o = pick(T_UNK, 6'd13, idx_i);
         end
      endcase
   end
endmodule

/* File: hdl/status_query_responder.v */
// Purpose: Command-level status queries, error store, reset, self test and tri-state control
// Assumes: All inputs synchronous to clk_sys_i; commands arrive one ASCII byte per write
// Notes: Replies are read one character per read of the reply register and repeat
`timescale 1ns/1ps
`include "dio_query_map.vh"

// Summary of operation
// - Data-ready query replies 1 captured, 0 none
// - Ready-for-data query replies 1 captured, 0 none
// - Interrupt reply hex; bits 0,2,3 enables
// - Interrupt reply bits 4,6,7 acknowledge snapshot
// - Level query: six-bit mask, 1 active high
// - Direction query: six-bit mask, 1 output
// - Error number as two digits, text message
// - Pulse reply bits 0-3 edges, 1 negative
// - Pulse reply bits 4,5 handshake enables
// - Sense query mask, 1 means low true
// - Tri-state query is external OR programmed
// - Strobe replies repeat until replaced
// - Pending error gives marker on D, R, I, L, M, P, S, T queries until acknowledged
// - Unknown query selector answers READY string
// - Power-up: strobes 1, tri-state 3F, rest 00
// - Self-test failure: error 01, byte, pattern
// - Overlong sequence raises error 15 with length
// - Output on input byte raises error 10
// - Reset command restores power-up configuration
// - Self test checks, restores, flags failure
// - Byte hi-Z if software or external active
// - Tri-state selectors 0-5 or asterisk
// - Letter A tri-states, I releases; no selector, no byte
// - Missing condition letter raises tri-state error
module status_query_responder (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire data_ready_strobe_i,
   input wire ready_for_data_strobe_i,
   input wire [5:0] external_tristate_lines_i,
   input wire seq_overflow_i,
   input wire [3:0] seq_len_i,
   input wire out_on_input_i,
   input wire [2:0] out_byte_i,
   input wire [7:0] test_return_i,
   output reg [5:0] byte_hiz_o,
   output reg [5:0] byte_is_output_o,
   output reg [5:0] byte_low_true_o,
   output reg fail_led_o,
   output reg test_active_o,
   output reg [2:0] test_byte_o,
   output reg [7:0] test_pattern_o
);
   // Command parser states
   localparam [1:0] P_IDLE = 2'd0;
   localparam [1:0] P_QSEL = 2'd1;
   localparam [1:0] P_TS = 2'd2;
   localparam [1:0] P_SKIP = 2'd3;

   reg [1:0] pstate;
   reg [3:0] read_mode;
   reg [5:0] reply_idx;
   reg [5:0] soft_ts;
   reg [5:0] ts_sel;
   reg [5:0] dir;
   reg [5:0] sense;
   reg [5:0] level;
   reg [5:0] pulse;
   reg [7:0] irq;
   reg drd_flag;
   reg rfd_flag;
   reg drd_prev;
   reg rfd_prev;
   reg [6:0] err_code;
   reg [7:0] err_arg_a;
   reg [7:0] err_arg_b;
   reg err_pending;
   reg st_busy;
   reg st_check;

   wire [7:0] cmd_ch = wdata_i[7:0];
   wire is_term = (cmd_ch == `CH_SEMI) || (cmd_ch == `CH_LF);
   wire is_blank = is_term || (cmd_ch == `CH_CR) || (cmd_ch == `CH_SPACE);
   wire is_sel = (cmd_ch >= `CH_ZERO) && (cmd_ch <= `CH_FIVE);

   // Edge detection with the programmed pulse edge bits; 1 selects the falling edge
   wire drd_edge = pulse[`PULSE_DRD_EDGE] ? (drd_prev & ~data_ready_strobe_i) :
                   (~drd_prev & data_ready_strobe_i);
   wire rfd_edge = pulse[`PULSE_RFD_EDGE] ? (rfd_prev & ~ready_for_data_strobe_i) :
                   (~rfd_prev & ready_for_data_strobe_i);

   // External line counts as active when it matches its programmed level
   wire [5:0] ext_active = ~(external_tristate_lines_i ^ level);
   wire [5:0] hiz_now = soft_ts | ext_active;

   // Reply body source
   reg [7:0] hex_val;
   reg [7:0] body_ch;
   reg [5:0] body_len;
   reg [7:0] reply_ch;
   wire [7:0] hex_hi;
   wire [7:0] hex_lo;
   wire [7:0] text_ch;
   wire [5:0] text_len;
   wire [6:0] err_tens = err_code / 7'd10;
   wire [6:0] err_ones = err_code % 7'd10;
   wire marker_mode = err_pending && (read_mode != `RM_TEXT) &&
                      (read_mode != `RM_NUM) && (read_mode != `RM_READY);

   hex_char u_hex_hi (
      .nib_i(hex_val[7:4]),
      .ch_o(hex_hi)
   );

   hex_char u_hex_lo (
      .nib_i(hex_val[3:0]),
      .ch_o(hex_lo)
   );

   reply_text u_text (
      .code_i(err_code),
      .arg_a_i(err_arg_a),
      .arg_b_i(err_arg_b),
      .idx_i(reply_idx),
      .ch_o(text_ch),
      .len_o(text_len)
   );

   // Value shown by the hex-formatted queries
   always @* begin
      case (read_mode)
         `RM_IRQ: hex_val = irq;
         `RM_LEVEL: hex_val = {2'b00, level};
         `RM_DIR: hex_val = {2'b00, dir};
         `RM_PULSE: hex_val = {2'b00, pulse};
         `RM_SENSE: hex_val = {2'b00, sense};
         `RM_TS: hex_val = {2'b00, hiz_now};
         default: hex_val = 8'h00;
      endcase
   end

   // Body character of the current reply; CR LF follow the body
   always @* begin
      body_ch = 8'h00;
      body_len = 6'd2;
      if (marker_mode) begin
         body_ch = (reply_idx == 6'd0) ? "Q" : "E";
      end else begin
         case (read_mode)
            `RM_TEXT: begin
               body_ch = text_ch;
               body_len = text_len;
            end
            `RM_NUM: begin
               body_ch = (reply_idx == 6'd0) ? (`CH_ZERO + {1'b0, err_tens}) :
                         (`CH_ZERO + {1'b0, err_ones});
            end
            `RM_DRD: begin
               body_ch = drd_flag ? "1" : "0";
               body_len = 6'd1;
            end
            `RM_RFD: begin
               body_ch = rfd_flag ? "1" : "0";
               body_len = 6'd1;
            end
            `RM_IRQ, `RM_LEVEL, `RM_DIR, `RM_PULSE, `RM_SENSE, `RM_TS: begin
               body_ch = (reply_idx == 6'd0) ? hex_hi : hex_lo;
            end
            default: begin
               body_len = 6'd5;
               case (reply_idx)
                  6'd0: body_ch = "R";
                  6'd1: body_ch = "E";
                  6'd2: body_ch = "A";
                  6'd3: body_ch = "D";
                  default: body_ch = "Y";
               endcase
            end
         endcase
      end
      if (reply_idx < body_len) begin
         reply_ch = body_ch;
      end else if (reply_idx == body_len) begin
         reply_ch = `CH_CR;
      end else begin
         reply_ch = `CH_LF;
      end
   end

   // Configuration back to its power-up values
   task power_up;
      begin
         soft_ts <= `RST_SOFT_TS;
         dir <= `RST_DIR;
         sense <= `RST_SENSE;
         level <= `RST_LEVEL;
         pulse <= `RST_PULSE;
         irq <= `RST_IRQ;
         drd_flag <= 1'b1;
         rfd_flag <= 1'b1;
         err_code <= `ERR_NONE;
         err_arg_a <= 8'h00;
         err_arg_b <= 8'h00;
         err_pending <= 1'b0;
         fail_led_o <= 1'b0;
         read_mode <= `RM_READY;
         reply_idx <= 6'd0;
         ts_sel <= 6'h00;
      end
   endtask

   // Main control: parser, registers, self test, error store
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pstate <= P_IDLE;
         read_mode <= `RM_READY;
         reply_idx <= 6'd0;
         soft_ts <= `RST_SOFT_TS;
         ts_sel <= 6'h00;
         dir <= `RST_DIR;
         sense <= `RST_SENSE;
         level <= `RST_LEVEL;
         pulse <= `RST_PULSE;
         irq <= `RST_IRQ;
         drd_flag <= 1'b1;
         rfd_flag <= 1'b1;
         drd_prev <= 1'b0;
         rfd_prev <= 1'b0;
         err_code <= `ERR_NONE;
         err_arg_a <= 8'h00;
         err_arg_b <= 8'h00;
         err_pending <= 1'b0;
         st_busy <= 1'b0;
         st_check <= 1'b0;
         rdata_o <= 32'h0;
         byte_hiz_o <= `RST_SOFT_TS;
         byte_is_output_o <= 6'h00;
         byte_low_true_o <= 6'h00;
         fail_led_o <= 1'b0;
         test_active_o <= 1'b0;
         test_byte_o <= 3'h0;
         test_pattern_o <= 8'h00;
      end else begin
         rdata_o <= 32'h0;
         drd_prev <= data_ready_strobe_i;
         rfd_prev <= ready_for_data_strobe_i;

         // Register writes; commands are dropped while the self test runs
         if (wr_i && !st_busy) begin
            case (addr_i)
               `OFS_CMD: begin
                  case (pstate)
                     P_IDLE: begin
                        if (cmd_ch == "Q") begin
                           pstate <= P_QSEL;
                        end else if (cmd_ch == "R") begin
                           power_up;
                        end else if (cmd_ch == "S") begin
                           st_busy <= 1'b1;
                           st_check <= 1'b0;
                           test_active_o <= 1'b1;
                           test_byte_o <= 3'h0;
                           test_pattern_o <= 8'h00;
                        end else if (cmd_ch == "T") begin
                           ts_sel <= 6'h00;
                           pstate <= P_TS;
                        end else if (!is_blank) begin
                           err_code <= `ERR_SYNTAX;
                           err_arg_a <= cmd_ch;
                           err_pending <= 1'b1;
                           pstate <= P_SKIP;
                        end
                     end
                     P_QSEL: begin
                        pstate <= P_IDLE;
                        reply_idx <= 6'd0;
                        case (cmd_ch)
                           "A": begin
                              read_mode <= `RM_TEXT;
                              err_pending <= 1'b0;
                           end
                           "N": begin
                              read_mode <= `RM_NUM;
                              err_pending <= 1'b0;
                           end
                           "D": read_mode <= `RM_DRD;
                           "R": read_mode <= `RM_RFD;
                           "I": read_mode <= `RM_IRQ;
                           "L": read_mode <= `RM_LEVEL;
                           "M": read_mode <= `RM_DIR;
                           "P": read_mode <= `RM_PULSE;
                           "S": read_mode <= `RM_SENSE;
                           "T": read_mode <= `RM_TS;
                           default: read_mode <= `RM_READY;
                        endcase
                     end
                     P_TS: begin
                        if (is_sel) begin
                           ts_sel <= ts_sel | (6'h01 << cmd_ch[2:0]);
                        end else if (cmd_ch == `CH_STAR) begin
                           ts_sel <= `MASK_BYTES;
                        end else if (cmd_ch == "A") begin
                           soft_ts <= soft_ts | ts_sel;
                           ts_sel <= 6'h00;
                        end else if (cmd_ch == "I") begin
                           soft_ts <= soft_ts & ~ts_sel;
                           ts_sel <= 6'h00;
                        end else if (is_term) begin
                           pstate <= P_IDLE;
                           if (ts_sel != 6'h00) begin
                              err_code <= `ERR_TRISTATE;
                              err_arg_a <= cmd_ch;
                              err_pending <= 1'b1;
                           end
                        end else if (cmd_ch != `CH_CR) begin
                           err_code <= `ERR_TRISTATE;
                           err_arg_a <= cmd_ch;
                           err_pending <= 1'b1;
                           pstate <= P_SKIP;
                        end
                     end
                     P_SKIP: begin
                        if (is_term) pstate <= P_IDLE;
                     end
                     default: pstate <= P_IDLE;
                  endcase
               end
               `OFS_DIR: dir <= wdata_i[5:0];
               `OFS_SENSE: sense <= wdata_i[5:0];
               `OFS_LEVEL: level <= wdata_i[5:0];
               `OFS_PULSE: pulse <= wdata_i[5:0];
               `OFS_IRQ: irq <= wdata_i[7:0] & `MASK_IRQ;
               `OFS_STRB_CLR: begin
                  if (wdata_i[`STRB_CLR_DRD]) drd_flag <= 1'b0;
                  if (wdata_i[`STRB_CLR_RFD]) rfd_flag <= 1'b0;
               end
               default: ;
            endcase
         end

         // Register reads; data stands in the following cycle only
         if (rd_i) begin
            case (addr_i)
               `OFS_REPLY: begin
                  rdata_o <= {24'h0, reply_ch};
                  reply_idx <= (reply_ch == `CH_LF) ? 6'd0 : reply_idx + 6'd1;
               end
               `OFS_STATUS: begin
                  rdata_o <= {27'h0, fail_led_o, rfd_flag, drd_flag, err_pending, st_busy};
               end
               `OFS_DIR: rdata_o <= {26'h0, dir};
               `OFS_SENSE: rdata_o <= {26'h0, sense};
               `OFS_LEVEL: rdata_o <= {26'h0, level};
               `OFS_PULSE: rdata_o <= {26'h0, pulse};
               `OFS_IRQ: rdata_o <= {24'h0, irq};
               default: rdata_o <= 32'h0;
            endcase
         end

         // Captured strobes; capture wins over a same-cycle clear
         if (drd_edge) drd_flag <= 1'b1;
         if (rfd_edge) rfd_flag <= 1'b1;

         // Errors reported by the load logic; set wins over acknowledge
         if (seq_overflow_i) begin
            err_code <= `ERR_SEQ_LEN;
            err_arg_a <= {4'h0, seq_len_i};
            err_pending <= 1'b1;
         end
         if (out_on_input_i) begin
            err_code <= `ERR_OUT_ON_IN;
            err_arg_a <= {5'h00, out_byte_i};
            err_pending <= 1'b1;
         end

         // Wraparound test: drive pattern, then compare on the next cycle
         if (st_busy) begin
            st_check <= ~st_check;
            if (st_check) begin
               if (test_return_i != test_pattern_o) begin
                  power_up;
                  st_busy <= 1'b0;
                  test_active_o <= 1'b0;
                  err_code <= `ERR_SELFTEST;
                  err_arg_a <= {5'h00, test_byte_o};
                  err_arg_b <= test_pattern_o;
                  err_pending <= 1'b1;
                  fail_led_o <= 1'b1;
               end else if (test_pattern_o == `ST_LAST_PAT) begin
                  test_pattern_o <= 8'h00;
                  if (test_byte_o == `ST_LAST_BYTE) begin
                     power_up;
                     st_busy <= 1'b0;
                     test_active_o <= 1'b0;
                  end else begin
                     test_byte_o <= test_byte_o + 3'h1;
                  end
               end else begin
                  test_pattern_o <= test_pattern_o + 8'h01;
               end
            end
         end

         // Pin-facing state; direction is never touched by tri-state control
         byte_hiz_o <= hiz_now;
         byte_is_output_o <= dir;
         byte_low_true_o <= sense;
      end
   end
endmodule

/* File: tb/io_loopback.sv */
// Purpose: Wraparound fixture on the I/O pins during self test
// Assumes: Driven straight from the responder
// Notes: Idle lines show the inverse pattern
`timescale 1ns/1ps
module io_loopback (
   input wire active_i,
   input wire [2:0] byte_i,
   input wire [7:0] pat_i,
   input wire fault_i,
   output wire [7:0] ret_o
);
   // Breaks byte 3 at pattern 80 when asked to
   wire hit = fault_i && byte_i == 3'h3 && pat_i == 8'h80;
   assign ret_o = (!active_i || hit) ? ~pat_i : pat_i;
endmodule

/* File: tb/sqr_chk.sv */
// Purpose: Port checks of the status query responder
// Assumes: Level register written only at its own offset
// Notes: Only the external share of tri-state is seen
`timescale 1ns/1ps
`include "dio_query_map.vh"
module sqr_chk (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire [5:0] external_tristate_lines_i,
   input wire [7:0] test_return_i,
   input wire [5:0] byte_hiz_o,
   input wire [5:0] byte_is_output_o,
   input wire [5:0] byte_low_true_o,
   input wire fail_led_o,
   input wire test_active_o,
   input wire [2:0] test_byte_o,
   input wire [7:0] test_pattern_o
);
   reg [5:0] lvl;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // Level mask shadow, to know the active line state
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lvl <= 6'h00;
      end else if (wr_i && addr_i == `OFS_LEVEL) begin
         lvl <= wdata_i[5:0];
      end
   end
   wire [5:0] ext_act = ~(external_tristate_lines_i ^ lvl);
   sequence st_start;
      $rose(test_active_o);
   endsequence
   sequence pat_moved;
      test_active_o && $past(test_active_o) && $changed(test_pattern_o);
   endsequence
   read_quiet_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("stray read data");
   hiz_or_a: assert property ($stable(ext_act) |-> (byte_hiz_o & ext_act) == ext_act)
      else $error("external hi-z lost");
   st_start_a: assert property (st_start |-> test_byte_o == 3'h0 && test_pattern_o == 8'h00)
      else $error("bad test start");
   pat_hold_a: assert property (pat_moved |=> !test_active_o || $stable(test_pattern_o))
      else $error("pattern held too short");
   pat_step_a: assert property (pat_moved |-> test_pattern_o == $past(test_pattern_o) + 8'h01)
      else $error("pattern skipped");
   byte_step_a: assert property (test_active_o && $past(test_active_o) && $changed(test_byte_o)
      |-> test_byte_o == $past(test_byte_o) + 3'h1) else $error("byte skipped");
   fail_end_a: assert property ($rose(fail_led_o) |-> $past(test_active_o))
      else $error("stray fail light");
   fail_cause_a: assert property ($rose(fail_led_o)
      |-> $past(test_return_i) != $past(test_pattern_o)) else $error("fail without mismatch");
   restore_a: assert property ($fell(test_active_o) |-> ##[0:2] (byte_is_output_o == 6'h00
      && byte_low_true_o == 6'h00 && byte_hiz_o == 6'h3f)) else $error("no power-up state");
endmodule
bind status_query_responder sqr_chk chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .external_tristate_lines_i(external_tristate_lines_i), .test_return_i(test_return_i),
   .byte_hiz_o(byte_hiz_o), .byte_is_output_o(byte_is_output_o),
   .byte_low_true_o(byte_low_true_o), .fail_led_o(fail_led_o), .test_active_o(test_active_o),
   .test_byte_o(test_byte_o), .test_pattern_o(test_pattern_o));

/* File: tb/tb_status_query_responder.sv */
// Purpose: Bench of the status query responder
// Assumes: One character per write or read
// Notes: Watchdog covers two self tests
`timescale 1ns/1ps
`include "dio_query_map.vh"
module tb_status_query_responder;
   reg clk_sys_i = 1'b0;
   reg resetn_i = 1'b0;
   reg [7:0] addr_i = 8'h00;
   reg [31:0] wdata_i = 32'h0;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg data_ready_strobe = 1'b0;
   reg ready_for_data_strobe = 1'b0;
   reg [5:0] ext = 6'h3f;
   reg ovf = 1'b0;
   reg [3:0] len = 4'h0;
   reg ooi = 1'b0;
   reg [2:0] obyte = 3'h0;
   reg fault = 1'b0;
   wire [31:0] rdata_o;
   wire [7:0] ret, tpat;
   wire [5:0] hiz, dir, low;
   wire led, act;
   wire [2:0] tbyte;
   integer mismatches = 0;
   integer check_count = 0;
   integer n;
   string z = "ILMNPS";
   status_query_responder uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .data_ready_strobe_i(data_ready_strobe), .ready_for_data_strobe_i(ready_for_data_strobe),
      .external_tristate_lines_i(ext), .seq_overflow_i(ovf), .seq_len_i(len),
      .out_on_input_i(ooi), .out_byte_i(obyte), .test_return_i(ret), .byte_hiz_o(hiz),
      .byte_is_output_o(dir), .byte_low_true_o(low), .fail_led_o(led),
      .test_active_o(act), .test_byte_o(tbyte), .test_pattern_o(tpat));
   io_loopback fix (.active_i(act), .byte_i(tbyte), .pat_i(tpat), .fault_i(fault), .ret_o(ret));
   // 25 MHz system clock
   always #20 clk_sys_i = ~clk_sys_i;
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_sys_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clk_sys_i);
         wr_i <= 1'b0;
      end
   endtask
   task cmd(input string s);
      integer i;
      begin
         for (i = 0; i < s.len(); i = i + 1) begin
            wr(`OFS_CMD, {24'h0, s[i]});
         end
      end
   endtask
   // Whole reply with CR LF; data stands one cycle
   task rep(input string e);
      integer i;
      string t;
      begin
         t = {e, "\015\012"};
         for (i = 0; i < t.len(); i = i + 1) begin
            @(posedge clk_sys_i);
            addr_i <= `OFS_REPLY;
            rd_i <= 1'b1;
            @(posedge clk_sys_i);
            rd_i <= 1'b0;
            #1;
            chk({"reply ", e}, rdata_o, {24'h0, t[i]});
         end
      end
   endtask
   task q(input [7:0] s, input string e);
      begin
         cmd("Q");
         wr(`OFS_CMD, {24'h0, s});
         rep(e);
      end
   endtask
   // Self test, bounded wait
   task st;
      integer i;
      begin
         cmd("S");
         #1;
         for (i = 0; i < 4000 && act === 1'b1; i = i + 1) begin
            @(posedge clk_sys_i);
            #1;
         end
         chk("busy", act, 32'h0);
         repeat (2) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   // Watchdog past two self tests
   initial begin
      #(40 * 30000);
      mismatches = mismatches + 1;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      rep("READY");
      q("A", "NO ERRORS");
      q("D", "1");
      q("R", "1");
      for (n = 0; n < 6; n = n + 1) begin
         q(z[n], "00");
      end
      q("T", "3F");
      wr(`OFS_STRB_CLR, 32'h3);
      q("D", "0");
      data_ready_strobe <= 1'b1;
      rep("1");
      q("R", "0");
      ready_for_data_strobe <= 1'b1;
      rep("1");
      wr(`OFS_IRQ, 32'hff);
      q("I", "DD");
      wr(`OFS_LEVEL, 32'h2a);
      q("L", "2A");
      wr(`OFS_DIR, 32'h15);
      q("M", "15");
      wr(`OFS_PULSE, 32'h3f);
      q("P", "3F");
      wr(`OFS_STRB_CLR, 32'h1);
      data_ready_strobe <= 1'b0;
      q("D", "1");
      wr(`OFS_SENSE, 32'h21);
      q("S", "21");
      chk("sense", low, 32'h21);
      ext <= 6'h15;
      cmd("T*I;");
      q("T", "00");
      chk("hiz", hiz, 32'h0);
      ext <= 6'h17;
      cmd("T03A;");
      q("T", "0B");
      chk("hiz", hiz, 32'h0b);
      chk("dir", dir, 32'h15);
      cmd("T2;");
      rep("QE");
      q("N", "07");
      q("A", "INVALID TRI-STATE COMMAND ';'");
      q("T", "0B");
      q("Z", "READY");
      ovf <= 1'b1;
      len <= 4'h7;
      @(posedge clk_sys_i);
      ovf <= 1'b0;
      q("N", "15");
      q("A", "MAXIMUM SEQUENCE LENGTH EXCEEDED - 07");
      ooi <= 1'b1;
      obyte <= 3'h4;
      @(posedge clk_sys_i);
      ooi <= 1'b0;
      q("N", "10");
      q("A", "OUTPUT SPECIFIED ON AN INPUT BYTE - 4");
      wr(`OFS_LEVEL, 32'h0);
      ext <= 6'h3f;
      cmd("R");
      q("M", "00");
      q("T", "3F");
      chk("sense", low, 32'h0);
      st;
      chk("fail led", led, 32'h0);
      q("N", "00");
      fault <= 1'b1;
      st;
      chk("fail led", led, 32'h1);
      q("N", "01");
      q("A", "SELF TEST FAILURE BYTE 3 COUNT 128");
      wrap_up;
   end
endmodule
